/* File: dv/rqo_cap.sv */
// capture register model on the far side of the ddr lanes
`timescale 1ns/1ps
module rqo_cap (
    input  wire logic        clk,
    input  wire logic        dclk,
    input  wire logic        oe_n,
    input  wire logic [10:0] ab,
    input  wire logic [10:0] cd,
    output logic [43:0]      word
);
    logic        dclk_q = 1'b0;
    logic [21:0] hi;
    always @(posedge clk) begin
        dclk_q <= dclk;
        if (!oe_n && dclk && !dclk_q) begin
            hi <= {cd, ab};
        end
        if (!oe_n && !dclk && dclk_q) begin
            word <= {cd, hi[21:11], ab, hi[10:0]};
        end
    end
endmodule

/* File: dv/rqo_chk.sv */
// assertion checker bound to the requantizer output block
`timescale 1ns/1ps
module rqo_chk (
    input wire logic                   clk,
    input wire logic                   srst,
    input wire logic                   samp_take,
    input wire logic                   power_down_request,
    input wire logic [7:0]             reg_addr,
    input wire logic [7:0]             reg_wdata,
    input wire logic                   reg_we,
    input wire logic                   reg_re,
    input wire logic [7:0]             reg_rdata,
    input wire logic [rqo_pkg::SW-1:0] lane_ab,
    input wire logic [rqo_pkg::SW-1:0] lane_cd,
    input wire logic                   output_data_clock,
    input wire logic                   out_oe_n
);
    import rqo_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_fmt_wr;
        reg_we && !reg_re && reg_addr == ADDR_FMT;
    endsequence
    sequence s_fmt_rd;
        reg_re && !reg_we && reg_addr == ADDR_FMT;
    endsequence
    a_off_hiz: assert property (power_down_request[*3] |-> out_oe_n)
        else $error("drivers on during power down");
    a_off_clk_still: assert property (power_down_request[*4] |-> $stable(output_data_clock))
        else $error("data clock runs during power down");
    a_reset_vals: assert property ($fell(srst) |-> out_oe_n && !output_data_clock
        && lane_ab == '0 && lane_cd == '0 && reg_rdata == 8'h00)
        else $error("bad values after reset");
    a_unmapped_zero: assert property (reg_re && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (!reg_re |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_take_gap: assert property (samp_take |=> !samp_take)
        else $error("two samples taken in one period");
    a_lane_hold: assert property (!out_oe_n && !$past(out_oe_n) && $stable(output_data_clock)
        && !samp_take
        |-> $stable(lane_ab) && $stable(lane_cd))
        else $error("lanes moved inside a half period");
    a_fmt_readback: assert property (s_fmt_wr ##2 s_fmt_rd |=>
        reg_rdata == ($past(reg_wdata, 3) & 8'h01))
        else $error("format register readback wrong");
endmodule
bind rqo_top rqo_chk chk (.*);

/* File: dv/rqo_top_tb.sv */
// self-checking bench of the requantizer output block
`timescale 1ns/1ps
module rqo_top_tb;
    import rqo_pkg::*;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [43:0] samp_in = '0;
    logic        samp_valid = 1'b0;
    logic        sync_in = 1'b0;
    logic        mode_sel = 1'b1;
    logic        power_down_request = 1'b0;
    logic [7:0]  reg_addr = '0;
    logic [7:0]  reg_wdata = '0;
    logic        reg_we = 1'b0;
    logic        reg_re = 1'b0;
    logic [7:0]  reg_rdata;
    logic [10:0] lane_ab, lane_cd;
    logic        samp_ready, samp_take, output_data_clock, out_oe_n;
    logic [43:0] word;
    int          errors = 0, n_tests = 0, cyc = 0, n, t[2], w[4];
    // twos, pin, a, b, expected a, expected b
    logic [45:0] rows [6] = '{
        {2'b01, 11'h000, 11'h7FF, 11'h000, 11'h7FF}, {2'b01, 11'h400, 11'h123, 11'h400, 11'h123},
        {2'b11, 11'h000, 11'h7FF, 11'h400, 11'h3FF}, {2'b11, 11'h400, 11'h555, 11'h000, 11'h155},
        {2'b00, 11'h7FF, 11'h000, 11'h7BB, 11'h044}, {2'b10, 11'h400, 11'h7FF, 11'h000, 11'h3BB}};
    // control, tuning word, upper edge
    logic [23:0] edges [7] = '{24'h000A36, 24'h020A4C, 24'h040A52, 24'h003F64,
        24'h023F63, 24'h043F63, 24'h060A2C};
    logic [10:0] lv [2] = '{11'h2AA, 11'h155};
    rqo_top #(.FIFO_DEPTH(16), .CNT_W(20)) dut (.*);
    rqo_cap cap (.clk(clk), .dclk(output_data_clock), .oe_n(out_oe_n), .ab(lane_ab),
        .cd(lane_cd), .word(word));
    initial begin
        forever #4 clk = ~clk;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic chk(input string what, input logic [43:0] exp, input logic [43:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge clk);
        reg_we <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge clk);
        reg_re <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask
    // wake time grows with the time spent asleep
    task automatic sleep(input bit pin, input logic [7:0] pv, input int k,
                         input logic [3:0] st, output int wt);
        logic [7:0] r;
        if (pin) power_down_request <= 1'b1;
        else wr(ADDR_PWR, pv);
        tick(k);
        rd(ADDR_STATUS, r);
        chk("state", st, r[7:4]);
        chk("hiz", 1'b1, out_oe_n);
        if (pin) power_down_request <= 1'b0;
        else wr(ADDR_PWR, 8'h00);
        wt = 0;
        do begin @(posedge clk); wt++; end while (out_oe_n !== 1'b0 && wt < 5000);
        chk("woke", 1'b1, wt < 5000);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            errors++;
            summarize();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] r;
        tick(4);
        srst <= 1'b0;
        samp_valid <= 1'b1;
        rd(ADDR_CHAN_IDX, r);
        chk("chan idx", CHAN_IDX_RST, r);
        rd(ADDR_NS_CTRL, r);
        chk("ns ctrl", NS_CTRL_RST, r);
        rd(8'h00, r);
        chk("unmapped", 8'h00, r);
        foreach (rows[i]) begin
            mode_sel <= rows[i][44];
            wr(ADDR_FMT, {7'h7F, rows[i][45]});
            rd(ADDR_FMT, r);
            chk("fmt", rows[i][45], r);
            samp_in <= {rows[i][43:33], rows[i][32:22], rows[i][32:22], rows[i][43:33]};
            tick(40);
            chk("word", {rows[i][21:11], rows[i][10:0], rows[i][10:0], rows[i][21:11]}, word);
        end
        foreach (edges[i]) begin
            wr(ADDR_NS_CTRL, edges[i][23:16]);
            wr(ADDR_NS_TUNE, edges[i][15:8]);
            rd(ADDR_NS_EDGE, r);
            chk("edge", edges[i][7:0], r);
        end
        $display("codes and bands done");
        mode_sel <= 1'b0;
        wr(ADDR_CHAN_IDX, 8'h01);
        wr(ADDR_NS_CTRL, 8'h10);
        rd(ADDR_STATUS, r);
        chk("enables", 4'hE, r[3:0]);
        wr(ADDR_NS_CTRL, 8'h11);
        mode_sel <= 1'b1;
        tick(4);
        rd(ADDR_STATUS, r);
        chk("enables", 4'h1, r[3:0]);
        wr(ADDR_NS_CTRL, 8'h00);
        wr(ADDR_FMT, 8'h00);
        foreach (lv[k]) begin
            do @(posedge clk); while (samp_take !== 1'b1);
            samp_in <= {4{lv[k]}};
            n = 0;
            do begin @(posedge clk); n++; end while (lane_ab !== lv[k] && n < 99);
            t[k] = n;
        end
        chk("latency", t[0], t[1]);
        chk("seen", 1'b1, t[0] < 99);
        sleep(1, 8'h00, 20, 4'h2, w[0]);
        sleep(1, 8'h00, 1000, 4'h2, w[1]);
        sleep(0, 8'h02, 1000, 4'h4, w[2]);
        sleep(0, 8'h01, 20, 4'h2, w[3]);
        chk("short wake", 1'b1, w[0] < w[1]);
        chk("standby wake", 1'b1, w[2] < w[1]);
        $display("power done");
        wr(ADDR_CLKDIV, 8'h07);
        wr(ADDR_SYNC, 8'h03);
        for (int k = 0; k < 2; k++) begin
            do @(posedge clk); while (samp_take !== 1'b1);
            tick(1 + 4 * k);
            sync_in <= 1'b1;
            n = 0;
            do begin @(posedge clk); n++; end while (samp_take !== 1'b1 && n < 40);
            sync_in <= 1'b0;
            t[k] = n;
        end
        chk("sync", t[0], t[1]);
        $display("sync done");
        srst <= 1'b1;
        tick(2);
        srst <= 1'b0;
        rd(ADDR_FMT, r);
        chk("fmt reset", FMT_RST, r);
        chk("ready", 1'b1, samp_ready);
        $display("reset done");
        summarize();
    end
endmodule

/* File: hw/rqo_fifo.sv */
// sample fifo with registered full and empty flags
`timescale 1ns/1ps
module rqo_fifo #(
    parameter int W = 44,
    parameter int D = 16
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0]   count_reg;
    logic          push;
    logic          pop;
    logic [AW:0]   count_next;

    assign push       = in_valid && in_ready;
    assign pop        = out_valid && out_ready;
    assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
    assign out_data   = mem[rd_ptr_reg];

    // ----------------------------------------------------------------
    // storage and pointers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(D-1)) ? '0 : wr_ptr_reg + AW'(1);
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(D-1)) ? '0 : rd_ptr_reg + AW'(1);
            end
        end
    end

    // ----------------------------------------------------------------
    // flags kept in flops so the ready seen upstream is glitch free
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            count_reg <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            count_reg <= count_next;
            in_ready  <= (count_next != (AW+1)'(D));
            out_valid <= (count_next != '0);
        end
    end
endmodule

/* File: hw/rqo_top.sv */
// requantizer back end: config registers, divider alignment, power, ddr output
`timescale 1ns/1ps
// Function
// - power-down request tristates output drivers
// - pin low releases power-down, resumes output
// - off stops clock; wake grows with time
// - standby keeps reference, wakes faster
// - alignment input passes two-flop synchroniser
// - valid pulse resets divider; bit selects every
// - host selects offset binary or twos complement
// - sample appears nine sample periods later
// - data clock high a/c, low b/d
// - 11-bit codes; twos inverts top bit
// - noise shaper attenuates by 0.6 dB
// - per-channel enable from register or pin
// - mode 000 selects 22 percent, 57 words
// - mode 001 selects 33 percent, 34 words
// - mode 010 selects 36 percent, 28 words
// - lower edge tuning times half percent
// - mode pin low enables, high plain output
// - override bit ignores pin per channel
module rqo_top #(
    parameter int FIFO_DEPTH = 16,
    parameter int CNT_W      = 20
) (
    input  wire logic                                  clk,
    input  wire logic                                  srst,
    input  wire logic [rqo_pkg::NCH*rqo_pkg::SW-1:0]   samp_in,
    input  wire logic                                  samp_valid,
    output logic                                       samp_ready,
    output logic                                       samp_take,
    input  wire logic                                  sync_in,
    input  wire logic                                  mode_sel,
    input  wire logic                                  power_down_request,
    input  wire logic [7:0]                            reg_addr,
    input  wire logic [7:0]                            reg_wdata,
    input  wire logic                                  reg_we,
    input  wire logic                                  reg_re,
    output logic [7:0]                                 reg_rdata,
    output logic [rqo_pkg::SW-1:0]                     lane_ab,
    output logic [rqo_pkg::SW-1:0]                     lane_cd,
    output logic                                       output_data_clock,
    output logic                                       out_oe_n
);
    import rqo_pkg::*;
    localparam int FW  = NCH*SW;
    localparam int PAD = LATENCY - 5;

    rqo_pwr_t         pwr_state;
    logic [CNT_W-1:0] off_cnt_reg;
    logic [CNT_W-1:0] wake_cnt_reg;
    logic [7:0]       chan_idx_reg;
    logic [7:0]       pwr_reg;
    logic [7:0]       clkdiv_reg;
    logic [7:0]       fmt_reg;
    logic [7:0]       sync_reg;
    logic [7:0]       ns_ctrl_reg [NCH];
    logic [7:0]       ns_tune_reg [NCH];
    logic [5:0]       tune_eff [NCH];
    logic [7:0]       edge_hi [NCH];
    logic [NCH-1:0]   ns_on;
    logic             sync_ff1_reg;
    logic             sync_ff2_reg;
    logic             sync_prev_reg;
    logic             sync_armed_reg;
    logic             sync_hit;
    logic [3:0]       ph_cnt_reg;
    logic [3:0]       div_n;
    logic             samp_en;
    logic             pd_req;
    logic             adv;
    logic [FW-1:0]    s1_reg;
    logic [FW-1:0]    s2_reg;
    logic [FW-1:0]    s3_reg;
    logic [2:0]       sv_reg;
    logic [FW-1:0]    fifo_dout;
    logic             fifo_ovalid;
    logic             fifo_iready;
    logic             pop;
    logic [FW-1:0]    pad_reg [PAD];
    logic [FW-1:0]    hold_reg;
    logic [FW-1:0]    out_word;
    logic [7:0]       rd_next;
    int               sel;

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            chan_idx_reg <= CHAN_IDX_RST;
            pwr_reg      <= PWR_RST;
            clkdiv_reg   <= CLKDIV_RST;
            fmt_reg      <= FMT_RST;
        end else if (reg_we) begin
            case (reg_addr)
                ADDR_CHAN_IDX: chan_idx_reg <= {4'h0, reg_wdata[3:0]};
                ADDR_PWR:      pwr_reg      <= {6'h00, reg_wdata[1:0]};
                ADDR_CLKDIV:   clkdiv_reg   <= {5'h00, reg_wdata[2:0]};
                ADDR_FMT:      fmt_reg      <= {7'h00, reg_wdata[FMT_TWOS_BIT]};
                default:       ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // alignment control; arming on write makes one-shot use possible
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            sync_reg       <= SYNC_RST;
            sync_armed_reg <= 1'b0;
        end else if (reg_we && reg_addr == ADDR_SYNC) begin
            sync_reg       <= {6'h00, reg_wdata[1:0]};
            sync_armed_reg <= 1'b1;
        end else if (sync_hit) begin
            sync_armed_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // per-channel noise shaper settings
    // ----------------------------------------------------------------
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        logic [2:0] mode;
        logic [5:0] tw;
        logic [5:0] lim;
        logic [7:0] step;
        assign mode = ns_ctrl_reg[c][NS_MODE_LSB +: 3];
        assign tw   = ns_tune_reg[c][5:0];
        assign lim  = (mode == NS_BW33) ? TW_CNT33 : (mode == NS_BW36) ? TW_CNT36 : TW_CNT22;
        assign step = (mode == NS_BW33) ? BW33_STEP : (mode == NS_BW36) ? BW36_STEP : BW22_STEP;
        assign tune_eff[c] = (mode > NS_BW36) ? 6'h00 : (tw >= lim) ? lim - 6'h01 : tw;
        assign edge_hi[c] = {2'h0, tune_eff[c]} + ((mode > NS_BW36) ? BW22_STEP : step);
        assign ns_on[c] = ns_ctrl_reg[c][NS_OVR_BIT] ? ns_ctrl_reg[c][NS_EN_BIT] : ~mode_sel;

        always_ff @(posedge clk) begin
            if (srst) begin
                ns_ctrl_reg[c] <= NS_CTRL_RST;
                ns_tune_reg[c] <= NS_TUNE_RST;
            end else if (reg_we && chan_idx_reg[c]) begin
                if (reg_addr == ADDR_NS_CTRL) begin
                    ns_ctrl_reg[c] <= {3'h0, reg_wdata[4:0]};
                end
                if (reg_addr == ADDR_NS_TUNE) begin
                    ns_tune_reg[c] <= {2'h0, reg_wdata[5:0]};
                end
            end
        end

        logic signed [SW-1:0]  sv;
        logic signed [SW+9:0]  prod;
        logic signed [SW-1:0]  att;
        assign sv   = {~s1_reg[c*SW+SW-1], s1_reg[c*SW +: SW-1]};
        assign prod = sv * $signed({1'b0, ATT_MULT});
        assign att  = prod[ATT_SHIFT +: SW];

        // one process per channel owns its stage flops
        logic [SW-1:0] s2_ch_reg;
        logic [SW-1:0] s3_ch_reg;
        always_ff @(posedge clk) begin
            if (adv) begin
                s2_ch_reg <= ns_on[c] ? att : sv;
                s3_ch_reg <= fmt_reg[FMT_TWOS_BIT] ? s2_ch_reg
                             : {~s2_ch_reg[SW-1], s2_ch_reg[SW-2:0]};
            end
        end
        assign s2_reg[c*SW +: SW] = s2_ch_reg;
        assign s3_reg[c*SW +: SW] = s3_ch_reg;
    end

    // ----------------------------------------------------------------
    // register reads; lowest selected channel answers
    // ----------------------------------------------------------------
    always_comb begin
        sel = 0;
        for (int c = NCH - 1; c >= 0; c--) begin
            if (chan_idx_reg[c]) begin
                sel = c;
            end
        end
        case (reg_addr)
            ADDR_CHAN_IDX: rd_next = chan_idx_reg;
            ADDR_PWR:      rd_next = pwr_reg;
            ADDR_CLKDIV:   rd_next = clkdiv_reg;
            ADDR_FMT:      rd_next = fmt_reg;
            ADDR_SYNC:     rd_next = sync_reg;
            ADDR_NS_CTRL:  rd_next = ns_ctrl_reg[sel];
            ADDR_NS_EDGE:  rd_next = edge_hi[sel];
            ADDR_NS_TUNE:  rd_next = ns_tune_reg[sel];
            ADDR_STATUS:   rd_next = {pwr_state, ns_on};
            default:       rd_next = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (reg_re) begin
            reg_rdata <= rd_next;
        end
    end

    // ----------------------------------------------------------------
    // alignment synchroniser and edge detect
    // ----------------------------------------------------------------
    // two-flop synchroniser
    always_ff @(posedge clk) begin
        if (srst) begin
            sync_ff1_reg  <= 1'b0;
            sync_ff2_reg  <= 1'b0;
            sync_prev_reg <= 1'b0;
        end else begin
            sync_ff1_reg  <= sync_in;
            sync_ff2_reg  <= sync_ff1_reg;
            sync_prev_reg <= sync_ff2_reg;
        end
    end

    assign sync_hit = sync_ff2_reg && !sync_prev_reg && sync_reg[SYNC_EN_BIT]
                      && (sync_reg[SYNC_EVERY_BIT] || sync_armed_reg);

    // ----------------------------------------------------------------
    // divider: a sample period spans two phases of div_n clocks each
    // ----------------------------------------------------------------
    assign div_n   = {1'b0, clkdiv_reg[2:0]} + 4'h1;
    assign samp_en = (ph_cnt_reg == 4'h0) && (pwr_state != PS_OFF);

    always_ff @(posedge clk) begin
        if (srst) begin
            ph_cnt_reg <= 4'h0;
        end else if (sync_hit) begin
            ph_cnt_reg <= 4'h0;
        end else if (pwr_state != PS_OFF) begin
            ph_cnt_reg <= (ph_cnt_reg >= {div_n[2:0], 1'b0} - 4'h1) ? 4'h0
                          : ph_cnt_reg + 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // power sequencing
    // ----------------------------------------------------------------
    assign pd_req = power_down_request || (pwr_reg[1:0] == PWR_OFF);

    always_ff @(posedge clk) begin
        if (srst) begin
            pwr_state    <= PS_RUN;
            off_cnt_reg  <= '0;
            wake_cnt_reg <= '0;
        end else begin
            case (pwr_state)
                PS_RUN: begin
                    off_cnt_reg <= '0;
                    if (pd_req) begin
                        pwr_state <= PS_OFF;
                    end else if (pwr_reg[1:0] == PWR_STBY) begin
                        pwr_state <= PS_STBY;
                    end
                end
                PS_OFF: begin
                    if (off_cnt_reg != '1) begin
                        off_cnt_reg <= off_cnt_reg + CNT_W'(1);
                    end
                    if (!pd_req) begin
                        pwr_state <= PS_WAKE;
                        wake_cnt_reg <= (off_cnt_reg >> WAKE_SHIFT) + CNT_W'(1);
                    end
                end
                PS_STBY: begin
                    if (pd_req) begin
                        pwr_state <= PS_OFF;
                    end else if (pwr_reg[1:0] != PWR_STBY) begin
                        pwr_state <= PS_WAKE;
                        wake_cnt_reg <= CNT_W'(STBY_WAKE);
                    end
                end
                PS_WAKE: begin
                    if (pd_req) begin
                        pwr_state   <= PS_OFF;
                        off_cnt_reg <= '0;
                    end else if (wake_cnt_reg <= CNT_W'(1)) begin
                        pwr_state <= PS_RUN;
                    end else begin
                        wake_cnt_reg <= wake_cnt_reg - CNT_W'(1);
                    end
                end
                default: pwr_state <= PS_RUN;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // front pipeline; stalls when the fifo is full
    // ----------------------------------------------------------------
    assign adv = samp_en && fifo_iready;

    always_ff @(posedge clk) begin
        if (srst) begin
            sv_reg    <= 3'h0;
            samp_take <= 1'b0;
        end else begin
            samp_take <= adv && samp_valid;
            if (adv) begin
                sv_reg <= {sv_reg[1:0], samp_valid};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (adv) begin
            s1_reg <= samp_in;
        end
    end

    assign samp_ready = fifo_iready;

    rqo_fifo #(
        .W (FW),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .srst      (srst),
        .in_data   (s3_reg),
        .in_valid  (adv && sv_reg[2]),
        .in_ready  (fifo_iready),
        .out_data  (fifo_dout),
        .out_valid (fifo_ovalid),
        .out_ready (pop)
    );

    // drain stops outside run, so the fifo really fills and stalls the source
    assign pop = samp_en && (pwr_state == PS_RUN);

    // ----------------------------------------------------------------
    // latency padding and ddr lanes
    // ----------------------------------------------------------------
    // fixed latency pad
    always_ff @(posedge clk) begin
        if (pop) begin
            hold_reg   <= pad_reg[PAD-1];
            pad_reg[0] <= fifo_ovalid ? fifo_dout : pad_reg[0];
            for (int i = 1; i < PAD; i++) begin
                pad_reg[i] <= pad_reg[i-1];
            end
        end
    end

    // both halves come from one sample, not across the pad shift
    assign out_word = pop ? pad_reg[PAD-1] : hold_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            lane_ab           <= '0;
            lane_cd           <= '0;
            output_data_clock <= 1'b0;
            out_oe_n          <= 1'b1;
        end else begin
            out_oe_n <= (pwr_state != PS_RUN);
            output_data_clock <= (ph_cnt_reg < div_n);
            if (ph_cnt_reg < div_n) begin
                lane_ab <= out_word[0*SW +: SW];
                lane_cd <= out_word[2*SW +: SW];
            end else begin
                lane_ab <= out_word[1*SW +: SW];
                lane_cd <= out_word[3*SW +: SW];
            end
        end
    end
endmodule

/* File: shared/rqo_pkg.sv */
// shared constants and types of the requantizer output control block
package rqo_pkg;
    // ----------------------------------------------------------------
    // geometry
    // ----------------------------------------------------------------
    localparam int NCH = 4;
    localparam int SW  = 11;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CHAN_IDX = 8'h05;
    localparam logic [7:0] ADDR_PWR      = 8'h08;
    localparam logic [7:0] ADDR_CLKDIV   = 8'h0B;
    localparam logic [7:0] ADDR_FMT      = 8'h14;
    localparam logic [7:0] ADDR_SYNC     = 8'h3A;
    localparam logic [7:0] ADDR_NS_CTRL  = 8'h3C;
    localparam logic [7:0] ADDR_NS_EDGE  = 8'h3D;
    localparam logic [7:0] ADDR_NS_TUNE  = 8'h3E;
    localparam logic [7:0] ADDR_STATUS   = 8'h3F;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int NS_EN_BIT      = 0;
    localparam int NS_MODE_LSB    = 1;
    localparam int NS_OVR_BIT     = 4;
    localparam int SYNC_EN_BIT    = 0;
    localparam int SYNC_EVERY_BIT = 1;
    localparam int FMT_TWOS_BIT   = 0;
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] CHAN_IDX_RST = 8'h0F;
    localparam logic [7:0] NS_CTRL_RST  = 8'h00;
    localparam logic [7:0] NS_TUNE_RST  = 8'h00;
    localparam logic [7:0] PWR_RST      = 8'h00;
    localparam logic [7:0] CLKDIV_RST   = 8'h00;
    localparam logic [7:0] FMT_RST      = 8'h00;
    localparam logic [7:0] SYNC_RST     = 8'h00;
    // ----------------------------------------------------------------
    // encodings and counts
    // ----------------------------------------------------------------
    localparam logic [2:0] NS_BW22   = 3'h0;
    localparam logic [2:0] NS_BW33   = 3'h1;
    localparam logic [2:0] NS_BW36   = 3'h2;
    localparam logic [5:0] TW_CNT22  = 6'h39;
    localparam logic [5:0] TW_CNT33  = 6'h22;
    localparam logic [5:0] TW_CNT36  = 6'h1C;
    localparam logic [7:0] BW22_STEP = 8'h2C;
    localparam logic [7:0] BW33_STEP = 8'h42;
    localparam logic [7:0] BW36_STEP = 8'h48;
    localparam logic [1:0] PWR_OFF   = 2'h1;
    localparam logic [1:0] PWR_STBY  = 2'h2;
    localparam logic [8:0] ATT_MULT  = 9'h0EF;
    localparam int         ATT_SHIFT = 8;
    localparam int         LATENCY   = 9;
    localparam int         WAKE_SHIFT = 4;
    localparam logic [19:0] STBY_WAKE = 20'h00010;
    typedef enum logic [3:0] {
        PS_RUN  = 4'h1,
        PS_OFF  = 4'h2,
        PS_STBY = 4'h4,
        PS_WAKE = 4'h8
    } rqo_pwr_t;
endpackage
